// ### hw/i2c_slave_status_control.sv
// top: i2c slave byte engine with status/control register behind apb
`timescale 1ns/100ps
// Overview of operation
// - after a full 8-bit data byte of an addressed frame has moved on the bus the transfer-done flag goes to one and an interrupt is raised.
// - while a data byte of an addressed frame is still being shifted the transfer-done flag stays zero; the address byte leaves it unchanged.
// - the addressed-as-slave flag is high when the calling address equals the own address, low otherwise.
// - a START condition sets the bus-busy flag.
// - a STOP condition clears the bus-busy flag.
// - master_read_request goes to one when the master asks to read, so the slave transmits.
// - master_read_request goes to zero when the master writes, so the slave receives.
// - the eighth bit after START, after seven address bits, is captured as master_read_request.
// - as receiver the slave drives the ack_to_send level on the ninth clock.
module i2c_slave_status_control
  import i2c_slv_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic IRQ,
  output logic WAKEUP_REQ
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE} phase_t;

  line_ev_t ev;
  phase_t phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] rx_data_r;
  logic done_r;
  logic aas_r;
  logic busy_r;
  logic mrr_r;
  logic rxack_r;
  logic drive_low_r;
  logic wake_r;
  logic [2:0] ctrl_bits;
  logic [6:0] own_addr;
  logic sleep_mode;
  logic [IRQ_W-1:0] irq_events;
  logic [7:0] status_control;

  // ----------------------------------------
  // line sampling and register file
  // ----------------------------------------
  i2c_line_sync u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .ev(ev)
  );

  i2c_apb_regs u_regs (
    .clk(REF_CLK),
    .srst(SRST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .status_control(status_control),
    .rx_data(rx_data_r),
    .irq_events(irq_events),
    .ctrl_bits(ctrl_bits),
    .own_addr(own_addr),
    .sleep_mode(sleep_mode),
    .irq(IRQ)
  );

  wire tx_select = ctrl_bits[2];
  wire ack_to_send = ctrl_bits[1];
  wire wake_en = ctrl_bits[0];

  // ----------------------------------------
  // status byte and event decode
  // ----------------------------------------
  assign status_control = {done_r, aas_r, busy_r, tx_select, ack_to_send, mrr_r, wake_en, rxack_r};
  wire byte_in = (bit_cnt_r == BITS_PER_BYTE - 4'h1) && ev.scl_rise;
  wire [7:0] byte_val = {shift_r[6:0], ev.sda};
  wire addr_hit = byte_val[7:1] == own_addr;
  wire in_data = phase_r == ST_DATA;
  wire done_evt = in_data && byte_in;
  wire match_evt = (phase_r == ST_ADDR) && byte_in && addr_hit;
  assign irq_events = {ev.stop, ev.start, match_evt, done_evt};
  // the slave only ever pulls sda low; the pad releases it otherwise
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~drive_low_r;
  assign WAKEUP_REQ = wake_r;

  // ----------------------------------------
  // bit counter and shifter, msb first
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || ev.start || ev.stop)
    begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end
    else if (ev.scl_rise)
    begin
      shift_r <= byte_val;
      bit_cnt_r <= (bit_cnt_r == ACK_SLOT - 4'h1) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // frame phase machine
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      phase_r <= ST_IDLE;
    else if (ev.stop)
      phase_r <= ST_IDLE;
    else if (ev.start)
      phase_r <= ST_ADDR;
    else if (ev.scl_rise)
    begin
      case (phase_r)
        ST_ADDR:
          if (bit_cnt_r == BITS_PER_BYTE - 4'h1)
            phase_r <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
        ST_ADDR_ACK:
          phase_r <= ST_DATA;
        ST_DATA:
          if (bit_cnt_r == BITS_PER_BYTE - 4'h1)
            phase_r <= ST_DATA_ACK;
        ST_DATA_ACK:
          phase_r <= ST_DATA;
        default:
          phase_r <= phase_r;
      endcase
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      done_r <= RST_STATUS_CONTROL[BIT_DONE];
      aas_r <= RST_STATUS_CONTROL[BIT_AAS];
      busy_r <= RST_STATUS_CONTROL[BIT_BUSY];
      mrr_r <= RST_STATUS_CONTROL[BIT_MRR];
      rxack_r <= RST_STATUS_CONTROL[BIT_RXACK];
      rx_data_r <= 8'h00;
    end
    else
    begin
      if (ev.start)
        busy_r <= 1'b1;
      else if (ev.stop)
        busy_r <= 1'b0;
      if (ev.start)
        aas_r <= 1'b0;
      else if (phase_r == ST_ADDR && byte_in)
        aas_r <= addr_hit;
      if (phase_r == ST_ADDR && byte_in)
        mrr_r <= ev.sda;
      if (in_data && ev.scl_rise && bit_cnt_r == 4'h0)
        done_r <= 1'b0;
      else if (done_evt)
        done_r <= 1'b1;
      if (done_evt)
        rx_data_r <= byte_val;
      if (phase_r == ST_DATA_ACK && ev.scl_rise)
        rxack_r <= ev.sda;
    end
  end

  // ----------------------------------------
  // sda pull-down: address ack, and data ack level as receiver
  // ----------------------------------------
  // changes only on scl low so the master never sees a false start/stop
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || ev.stop)
      drive_low_r <= 1'b0;
    else if (ev.scl_fall)
    begin
      if (phase_r == ST_ADDR_ACK)
        drive_low_r <= 1'b1;
      else if (phase_r == ST_DATA_ACK && !tx_select)
        drive_low_r <= ~ack_to_send;
      else
        drive_low_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // wake-up request, held until software leaves sleep
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || !sleep_mode)
      wake_r <= 1'b0;
    else if (match_evt && wake_en)
      wake_r <= 1'b1;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_on_start: assert property (@(posedge REF_CLK) disable iff (SRST)
    ev.start |=> busy_r)
    else $error("busy flag not set after start");
  a_busy_on_stop: assert property (@(posedge REF_CLK) disable iff (SRST)
    ev.stop && !ev.start |=> !busy_r)
    else $error("busy flag not cleared after stop");
  a_done_set: assert property (@(posedge REF_CLK) disable iff (SRST)
    done_evt |=> done_r && status_control[BIT_DONE])
    else $error("done flag not set after byte");
  a_done_low_shift: assert property (@(posedge REF_CLK) disable iff (SRST)
    in_data && bit_cnt_r != 4'h0 && $past(in_data) && !$past(done_evt) && !done_evt |-> !done_r)
    else $error("done flag high mid byte");
  a_match_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_ADDR && byte_in && !ev.start |=> aas_r == $past(addr_hit))
    else $error("address match flag wrong");
  a_rw_capture: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_ADDR && byte_in |=> mrr_r == $past(ev.sda))
    else $error("read/write bit not captured");
  a_rw_write: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_ADDR && byte_in && !ev.sda |=> !mrr_r)
    else $error("write request not shown");
  a_rw_eighth: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_ADDR && byte_in |-> bit_cnt_r == 4'h7)
    else $error("rw bit not the eighth");
  a_ack_drive: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_DATA_ACK && ev.scl_fall && !tx_select && !ev.stop |=> drive_low_r == !$past(ack_to_send))
    else $error("ack level not driven on ninth clock");
  a_wake_req: assert property (@(posedge REF_CLK) disable iff (SRST)
    match_evt && wake_en && sleep_mode |=> WAKEUP_REQ)
    else $error("wake-up request missing");

  // ----------------------------------------
  // frame sequencing and acknowledge checks
  // ----------------------------------------
  // a start always restarts the address phase from bit zero
  a_start_addr: assert property (@(posedge REF_CLK) disable iff (SRST)
    ev.start && !ev.stop |=> phase_r == ST_ADDR && bit_cnt_r == 4'h0)
    else $error("start did not restart address phase");
  // a stop always parks the frame machine
  a_stop_idle: assert property (@(posedge REF_CLK) disable iff (SRST)
    ev.stop |=> phase_r == ST_IDLE && !drive_low_r)
    else $error("stop did not end the frame");
  // the matched slave pulls sda low through the address ack slot
  a_addr_ack: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_ADDR_ACK && ev.scl_fall && !ev.stop |=> drive_low_r)
    else $error("address ack not driven on match");
  // a foreign address must leave the bus alone until the next condition
  a_ignore_quiet: assert property (@(posedge REF_CLK) disable iff (SRST)
    phase_r == ST_IGNORE && ev.scl_fall |=> !drive_low_r)
    else $error("sda pulled while ignoring frame");
  // the completed byte is what software reads back
  a_rx_capture: assert property (@(posedge REF_CLK) disable iff (SRST)
    done_evt |=> rx_data_r == $past(byte_val))
    else $error("received byte not captured");
  // leaving sleep always withdraws the wake-up request
  a_wake_awake: assert property (@(posedge REF_CLK) disable iff (SRST)
    !sleep_mode |=> !WAKEUP_REQ)
    else $error("wake-up request while awake");
  c_data_ack: cover property (@(posedge REF_CLK) phase_r == ST_DATA_ACK && !SDA_OE_N);
  c_match: cover property (@(posedge REF_CLK) match_evt);
  c_byte_done: cover property (@(posedge REF_CLK) done_evt);
  c_wake: cover property (@(posedge REF_CLK) $rose(WAKEUP_REQ));
  c_stop: cover property (@(posedge REF_CLK) busy_r ##1 !busy_r);
endmodule

// ### hw/i2c_slv_pkg.sv
// package: register map, field positions, reset values and shared types of the i2c slave status block
package i2c_slv_pkg;
  // register byte addresses (word aligned)
  localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000; // i2c_slave_status_control
  localparam logic [11:0] ADDR_OWN_ADDRESS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
  localparam logic [11:0] ADDR_RX_DATA = 12'h010;
  localparam logic [11:0] ADDR_POWER = 12'h014;
  // field positions inside i2c_slave_status_control
  localparam int BIT_DONE = 7;
  localparam int BIT_AAS = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_ACK = 3;
  localparam int BIT_MRR = 2;
  localparam int BIT_WAKE_EN = 1;
  localparam int BIT_RXACK = 0;
  // reset values
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h81;
  localparam logic [6:0] RST_OWN_ADDRESS = 7'h00;
  // interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_STOP = 3;
  localparam int IRQ_W = 4;
  // serial framing counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  // bus condition events seen on the serial lines
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } line_ev_t;
endpackage

// ### hw/i2c_line_sync.sv
// two-flop synchroniser and edge/condition detector for the serial lines
`timescale 1ns/100ps
module i2c_line_sync
  import i2c_slv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output line_ev_t ev
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_last_r;
  logic sda_last_r;

  // ----------------------------------------
  // synchronisers, idle high like the bus
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_last_r <= 1'b1;
      sda_last_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_last_r <= scl_sync_r[1];
      sda_last_r <= sda_sync_r[1];
    end
  end

  // only the second stage and its delayed copy feed the detectors
  assign ev.scl_rise = scl_sync_r[1] & ~scl_last_r;
  assign ev.scl_fall = ~scl_sync_r[1] & scl_last_r;
  assign ev.start = scl_sync_r[1] & scl_last_r & sda_last_r & ~sda_sync_r[1];
  assign ev.stop = scl_sync_r[1] & scl_last_r & ~sda_last_r & sda_sync_r[1];
  assign ev.sda = sda_sync_r[1];
endmodule

// ### hw/i2c_apb_regs.sv
// apb slave register file with sticky interrupt status and mask
`timescale 1ns/100ps
module i2c_apb_regs
  import i2c_slv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] status_control,
  input wire logic [7:0] rx_data,
  input wire logic [IRQ_W-1:0] irq_events,
  output logic [2:0] ctrl_bits,
  output logic [6:0] own_addr,
  output logic sleep_mode,
  output logic irq
);
  logic [2:0] ctrl_r;
  logic [6:0] own_r;
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] imask_r;
  logic sleep_r;
  logic [31:0] rdata_nxt;
  wire wr_en = psel & penable & pwrite;
  wire hit_sc = paddr == ADDR_STATUS_CONTROL;
  wire hit_own = paddr == ADDR_OWN_ADDRESS;
  wire hit_ist = paddr == ADDR_IRQ_STATUS;
  wire hit_msk = paddr == ADDR_IRQ_MASK;
  wire hit_rx = paddr == ADDR_RX_DATA;
  wire hit_pwr = paddr == ADDR_POWER;
  wire mapped = hit_sc | hit_own | hit_ist | hit_msk | hit_rx | hit_pwr;

  // ----------------------------------------
  // read decode: zero-wait, unmapped answers error
  // ----------------------------------------
  assign rdata_nxt = hit_sc ? {24'h0, status_control} :
                     hit_own ? {25'h0, own_r} :
                     hit_ist ? {{(32-IRQ_W){1'b0}}, ist_r} :
                     hit_msk ? {{(32-IRQ_W){1'b0}}, imask_r} :
                     hit_rx ? {24'h0, rx_data} :
                     hit_pwr ? {31'h0, sleep_r} : 32'h0;
  assign prdata = rdata_nxt;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign ctrl_bits = ctrl_r;
  assign own_addr = own_r;
  assign sleep_mode = sleep_r;
  assign irq = |(ist_r & imask_r);

  // ----------------------------------------
  // writable registers; event set beats a write-one clear
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r <= {RST_STATUS_CONTROL[BIT_TXSEL], RST_STATUS_CONTROL[BIT_ACK], RST_STATUS_CONTROL[BIT_WAKE_EN]};
      own_r <= RST_OWN_ADDRESS;
      ist_r <= '0;
      imask_r <= '0;
      sleep_r <= 1'b0;
    end
    else
    begin
      if (wr_en && hit_sc)
        ctrl_r <= {pwdata[BIT_TXSEL], pwdata[BIT_ACK], pwdata[BIT_WAKE_EN]};
      if (wr_en && hit_own)
        own_r <= pwdata[6:0];
      if (wr_en && hit_msk)
        imask_r <= pwdata[IRQ_W-1:0];
      if (wr_en && hit_pwr)
        sleep_r <= pwdata[0];
      ist_r <= (ist_r & ~((wr_en && hit_ist) ? pwdata[IRQ_W-1:0] : '0)) | irq_events;
    end
  end

  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    irq_events[IRQ_DONE] && imask_r[IRQ_DONE] |=> irq)
    else $error("masked-in done event did not raise irq");
endmodule

// ### dv/i2c_master_model.sv
// behavioural i2c bus master driving the slave's serial lines
`timescale 1ns/100ps
module i2c_master_model
(
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // ----------------------------------------
  // bus timing: 800 ns link period
  // ----------------------------------------
  localparam time HALF = 400;
  // lines idle high; clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // sda falls while scl high, then clock goes low
  task automatic start_cond();
    sda_drv = 1'b1;
    scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask
  // sda rises while scl high; bus released afterwards
  task automatic stop_cond();
    #(HALF/2) sda_drv = 1'b0;
    #(HALF/2) scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
  // data changes only mid-low so it never mimics a start or stop
  task automatic bit_out(input logic b);
    #(HALF/2) sda_drv = b;
    #(HALF/2) scl = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // release sda and sample the slave's answer mid-high
  task automatic ack_clk(output logic a);
    #(HALF/2) sda_drv = 1'b1;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) a = sda_line;
    #(HALF/2) scl = 1'b0;
  endtask
  // msb first, then the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      bit_out(b[i]);
    end
    ack_clk(a);
  endtask
endmodule

// ### dv/test_i2c_slave_status_control.sv
// testbench: apb register access plus i2c traffic from a master model
`timescale 1ns/100ps
module test_i2c_slave_status_control;
  import i2c_slv_pkg::*;
  // ----------------------------------------
  // clock, bus signals and device
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sda_out, sda_oe_n, irq, wakeup_req, scl, sda_drv, ack;
  int n_fail = 0;
  int comparisons = 0;
  // open-drain line: pull-up unless someone pulls low
  wire logic sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  i2c_master_model i_master (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  i2c_slave_status_control i_dut (.REF_CLK(ref_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .IRQ(irq), .WAKEUP_REQ(wakeup_req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // a slave that never answers is a failure, not a silent pass
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("BAD %0t apb transfer got no pready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // masked compare keeps live bits such as rx ack out of the check
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp, "register read");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog: tests need well under 1 ms
  initial
  begin
    #3000000;
    n_fail++;
    end_of_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // reset values, read-only bits, unmapped address
    wr(ADDR_STATUS_CONTROL, 32'he4);
    rd(ADDR_STATUS_CONTROL, 32'hffffffff, 32'h81);
    rd(ADDR_OWN_ADDRESS, 32'hffffffff, 32'h0);
    rd(ADDR_IRQ_MASK, 32'hffffffff, 32'h0);
    apb(1'b0, 12'hffc, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset done");
    // matching write address, then a byte watched mid-shift
    wr(ADDR_OWN_ADDRESS, 32'h2a);
    wr(ADDR_IRQ_MASK, 32'h0f);
    wr(ADDR_STATUS_CONTROL, 32'h00);
    i_master.start_cond();
    i_master.send_byte(8'h54, ack);
    chk({31'h0, ack}, 32'h0, "address ack");
    rd(ADDR_STATUS_CONTROL, 32'h64, 32'h60);
    rd(ADDR_IRQ_STATUS, 32'h0f, 32'h06);
    wr(ADDR_IRQ_STATUS, 32'h06);
    for (int i = 7; i >= 4; i--) i_master.bit_out(r[0] ^ 1'b0 | 8'ha5 >> i);
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h0);
    for (int i = 3; i >= 0; i--) i_master.bit_out(8'ha5 >> i);
    i_master.ack_clk(ack);
    chk({31'h0, ack}, 32'h0, "data ack low");
    rd(ADDR_STATUS_CONTROL, 32'h80, 32'h80);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(ADDR_IRQ_STATUS, 32'h0f, 32'h01);
    rd(ADDR_RX_DATA, 32'hffffffff, 32'ha5);
    wr(ADDR_IRQ_STATUS, 32'h01);
    // the clear lands at the edge that ends the access; look once it has settled
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // refused byte, then stop and masking
    wr(ADDR_STATUS_CONTROL, 32'h08);
    i_master.send_byte(8'h3c, ack);
    chk({31'h0, ack}, 32'h1, "data ack high");
    rd(ADDR_RX_DATA, 32'hffffffff, 32'h3c);
    i_master.stop_cond();
    rd(ADDR_STATUS_CONTROL, 32'h20, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h0f, 32'h09);
    wr(ADDR_IRQ_MASK, 32'h00);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_IRQ_STATUS, 32'h0f);
    $display("test write transfer done");
    // foreign address is ignored
    i_master.start_cond();
    i_master.send_byte(8'h56, ack);
    chk({31'h0, ack}, 32'h1, "no ack foreign");
    rd(ADDR_STATUS_CONTROL, 32'h40, 32'h0);
    i_master.stop_cond();
    // read request from the master
    i_master.start_cond();
    i_master.send_byte(8'h55, ack);
    rd(ADDR_STATUS_CONTROL, 32'h64, 32'h64);
    wr(ADDR_STATUS_CONTROL, 32'h10);
    rd(ADDR_STATUS_CONTROL, 32'h1a, 32'h10);
    i_master.stop_cond();
    $display("test address cases done");
    // wake-up on match while asleep
    wr(ADDR_POWER, 32'h1);
    wr(ADDR_STATUS_CONTROL, 32'h02);
    chk({31'h0, wakeup_req}, 32'h0, "no wake yet");
    i_master.start_cond();
    i_master.send_byte(8'h54, ack);
    i_master.stop_cond();
    chk({31'h0, wakeup_req}, 32'h1, "wake request");
    wr(ADDR_POWER, 32'h0);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, wakeup_req}, 32'h0, "wake cleared");
    $display("test wake done");
    end_of_test();
  end
endmodule
